/* hw/ssq_pkg.sv */
`default_nettype none
// ==========================================================
// Shared constants for the state sample clock qualifier
package ssq_pkg;
  // ==========================================================
  // Sizes
  localparam int NPOD = 5;
  localparam int NPOD_NARROW = 2;
  localparam int PODW = 16;
  localparam int BYTEW = 8;
  localparam int CONDW = 3;
  localparam int MODEW = 2;
  localparam int ARRW = NPOD * CONDW;
  localparam int MODESW = NPOD * MODEW;
  localparam int DATW = NPOD * PODW;
  localparam int CNTW = 16;
  localparam int ADDRW = 8;
  localparam int DW = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADDRW-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDRW-1:0] OFF_ARR_A = 8'h04;
  localparam logic [ADDRW-1:0] OFF_ARR_B = 8'h08;
  localparam logic [ADDRW-1:0] OFF_POD_MODE = 8'h0c;
  localparam logic [ADDRW-1:0] OFF_STATUS = 8'h10;
  localparam logic [ADDRW-1:0] OFF_COUNT = 8'h14;
  localparam logic [ADDRW-1:0] OFF_SAMPLE0 = 8'h18;
  localparam logic [ADDRW-1:0] OFF_STEP = 8'h04;

  // ==========================================================
  // Field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_TIMING = 1;
  localparam int CTRL_NARROW = 2;
  localparam int STAT_ERR = 0;
  localparam int STAT_ACTIVE = 1;

  // ==========================================================
  // Reset values
  localparam logic [ARRW-1:0] ARR_RST = 15'h0000;
  localparam logic [MODESW-1:0] MODES_RST = 10'h000;

  // ==========================================================
  // Per-clock condition codes
  localparam logic [CONDW-1:0] COND_OFF = 3'h0;
  localparam logic [CONDW-1:0] COND_FALL = 3'h1;
  localparam logic [CONDW-1:0] COND_RISE = 3'h2;
  localparam logic [CONDW-1:0] COND_EITHER = 3'h3;
  localparam logic [CONDW-1:0] COND_HIGH = 3'h4;
  localparam logic [CONDW-1:0] COND_LOW = 3'h5;

  // ==========================================================
  // Per-pod clocking modes
  localparam logic [MODEW-1:0] MODE_SINGLE = 2'h0;
  localparam logic [MODEW-1:0] MODE_SHARED = 2'h1;
  localparam logic [MODEW-1:0] MODE_SPLIT = 2'h2;

  // Capture phase
  typedef enum logic {PH_FIRST = 1'b0, PH_SECOND = 1'b1} ssq_phase_t;
endpackage
`default_nettype wire

/* hw/ssq_top.sv */
// Design decisions made here: the register addresses and strobed register access.
`default_nettype none
module ssq_top
(
  // System clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  // Register port
  input wire logic [ssq_pkg::ADDRW-1:0] ADDR_IN,
  input wire logic [ssq_pkg::DW-1:0] WR_DATA_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  output logic [ssq_pkg::DW-1:0] RD_DATA_OUT,
  // Target side, on the link clock
  input wire logic LINK_CLK_IN,
  input wire logic [ssq_pkg::NPOD-1:0] EDGE_SRC_IN,
  input wire logic [ssq_pkg::DATW-1:0] POD_DATA_IN,
  // Status
  output logic CFG_ERROR_OUT,
  output logic SAMPLE_STROBE_OUT
);

  // ==========================================================
  // State records
  typedef struct packed {
    logic run;
    logic timing;
    logic narrow;
    logic [ssq_pkg::ARRW-1:0] arr_a;
    logic [ssq_pkg::ARRW-1:0] arr_b;
    logic [ssq_pkg::MODESW-1:0] modes;
    logic [ssq_pkg::DW-1:0] rd_data;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic [ssq_pkg::DATW-1:0] sample;
    logic [ssq_pkg::CNTW-1:0] count;
    logic pulse;
    logic err;
  } ssq_sys_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic run_s1;
    logic run_s2;
    logic [ssq_pkg::NPOD-1:0] clk_s1;
    logic [ssq_pkg::NPOD-1:0] clk_s2;
    logic [ssq_pkg::NPOD-1:0] clk_s3;
    logic [ssq_pkg::NPOD-1:0] clk_v;
    logic [ssq_pkg::DATW-1:0] dat_s1;
    logic [ssq_pkg::DATW-1:0] dat_s2;
    logic [ssq_pkg::DATW-1:0] dat_s3;
    logic armed;
    logic narrow;
    logic [ssq_pkg::ARRW-1:0] arr_a;
    logic [ssq_pkg::ARRW-1:0] arr_b;
    logic [ssq_pkg::MODESW-1:0] modes;
    ssq_pkg::ssq_phase_t phase;
    logic [ssq_pkg::DATW-1:0] acc;
    logic [ssq_pkg::DATW-1:0] out;
    logic tog;
  } ssq_link_t;

  ssq_sys_t s;
  ssq_sys_t next_s;
  ssq_link_t l;
  ssq_link_t next_l;

  // ==========================================================
  // Arrangement evaluation
  // Edge hit of one arrangement against this cycle's clock changes
  function automatic logic arr_strobe(
    input logic [ssq_pkg::ARRW-1:0] arr,
    input logic [ssq_pkg::NPOD-1:0] rise,
    input logic [ssq_pkg::NPOD-1:0] fall,
    input logic [ssq_pkg::NPOD-1:0] lvl,
    input logic [ssq_pkg::NPOD-1:0] mask
  );
    logic edge_or;
    logic lvl_or;
    logic any_lvl;
    logic [ssq_pkg::CONDW-1:0] c;
    edge_or = 1'b0;
    lvl_or = 1'b0;
    any_lvl = 1'b0;
    for (int i = 0; i < ssq_pkg::NPOD; i++)
    begin
      c = mask[i] ? arr[i*ssq_pkg::CONDW +: ssq_pkg::CONDW]
                  : ssq_pkg::COND_OFF;
      case (c)
        ssq_pkg::COND_FALL: edge_or = edge_or | fall[i];
        ssq_pkg::COND_RISE: edge_or = edge_or | rise[i];
        ssq_pkg::COND_EITHER: edge_or = edge_or | rise[i] | fall[i];
        ssq_pkg::COND_HIGH:
        begin
          any_lvl = 1'b1;
          lvl_or = lvl_or | lvl[i];
        end
        ssq_pkg::COND_LOW:
        begin
          any_lvl = 1'b1;
          lvl_or = lvl_or | ~lvl[i];
        end
        default: ;
      endcase
    end
    // No level selected leaves the edge term alone
    return edge_or & (lvl_or | ~any_lvl);
  endfunction

  // True when the arrangement holds levels but not a single edge
  function automatic logic arr_bad(
    input logic [ssq_pkg::ARRW-1:0] arr,
    input logic [ssq_pkg::NPOD-1:0] mask
  );
    logic has_edge;
    logic has_lvl;
    logic [ssq_pkg::CONDW-1:0] c;
    has_edge = 1'b0;
    has_lvl = 1'b0;
    for (int i = 0; i < ssq_pkg::NPOD; i++)
    begin
      c = mask[i] ? arr[i*ssq_pkg::CONDW +: ssq_pkg::CONDW]
                  : ssq_pkg::COND_OFF;
      if (c == ssq_pkg::COND_FALL || c == ssq_pkg::COND_RISE ||
          c == ssq_pkg::COND_EITHER)
        has_edge = 1'b1;
      if (c == ssq_pkg::COND_HIGH || c == ssq_pkg::COND_LOW)
        has_lvl = 1'b1;
    end
    return has_lvl & ~has_edge;
  endfunction

  // Clocks that exist on the selected variant
  function automatic logic [ssq_pkg::NPOD-1:0] pod_mask(input logic narrow);
    logic [ssq_pkg::NPOD-1:0] m;
    for (int i = 0; i < ssq_pkg::NPOD; i++)
      m[i] = narrow ? (i < ssq_pkg::NPOD_NARROW) : 1'b1;
    return m;
  endfunction

  // ==========================================================
  // System domain: registers, error check, sample hand-back
  localparam int ADDRW = ssq_pkg::ADDRW;
  always_comb
  begin
    logic [ssq_pkg::NPOD-1:0] m;
    logic uses_two;
    logic [ssq_pkg::ADDRW-1:0] off;
    m = pod_mask(s.narrow);
    uses_two = 1'b0;
    off = 8'h00;
    next_s = s;
    next_s.pulse = 1'b0;
    for (int p = 0; p < ssq_pkg::NPOD; p++)
      if (m[p] && s.modes[p*ssq_pkg::MODEW +: ssq_pkg::MODEW] !=
          ssq_pkg::MODE_SINGLE)
        uses_two = 1'b1;
    // Level-only arrangements are never armed
    next_s.err = arr_bad(s.arr_a, m) | (uses_two & arr_bad(s.arr_b, m));
    // Writes, config held while running to keep the crossing quiet
    if (WR_EN_IN)
    begin
      case (ADDR_IN)
        ssq_pkg::OFF_CTRL:
        begin
          next_s.run = WR_DATA_IN[ssq_pkg::CTRL_RUN];
          next_s.timing = WR_DATA_IN[ssq_pkg::CTRL_TIMING];
          if (!s.run)
            next_s.narrow = WR_DATA_IN[ssq_pkg::CTRL_NARROW];
        end
        ssq_pkg::OFF_ARR_A:
          if (!s.run)
            next_s.arr_a = WR_DATA_IN[ssq_pkg::ARRW-1:0];
        ssq_pkg::OFF_ARR_B:
          if (!s.run)
            next_s.arr_b = WR_DATA_IN[ssq_pkg::ARRW-1:0];
        ssq_pkg::OFF_POD_MODE:
          if (!s.run)
            next_s.modes = WR_DATA_IN[ssq_pkg::MODESW-1:0];
        default: ;
      endcase
    end
    // Reads answer one cycle later, unmapped reads as zero
    next_s.rd_data = 32'h0000_0000;
    if (RD_EN_IN)
    begin
      case (ADDR_IN)
        ssq_pkg::OFF_CTRL:
        begin
          next_s.rd_data[ssq_pkg::CTRL_RUN] = s.run;
          next_s.rd_data[ssq_pkg::CTRL_TIMING] = s.timing;
          next_s.rd_data[ssq_pkg::CTRL_NARROW] = s.narrow;
        end
        ssq_pkg::OFF_ARR_A: next_s.rd_data[ssq_pkg::ARRW-1:0] = s.arr_a;
        ssq_pkg::OFF_ARR_B: next_s.rd_data[ssq_pkg::ARRW-1:0] = s.arr_b;
        ssq_pkg::OFF_POD_MODE:
          next_s.rd_data[ssq_pkg::MODESW-1:0] = s.modes;
        ssq_pkg::OFF_STATUS:
        begin
          next_s.rd_data[ssq_pkg::STAT_ERR] = s.err;
          next_s.rd_data[ssq_pkg::STAT_ACTIVE] =
            s.run & ~s.timing & ~s.err;
        end
        ssq_pkg::OFF_COUNT: next_s.rd_data[ssq_pkg::CNTW-1:0] = s.count;
        default:
          for (int p = 0; p < ssq_pkg::NPOD; p++)
          begin
            off = ssq_pkg::OFF_SAMPLE0 + ADDRW'(p) * ssq_pkg::OFF_STEP;
            if (ADDR_IN == off &&
                (!s.narrow || p < ssq_pkg::NPOD_NARROW))
              next_s.rd_data[ssq_pkg::PODW-1:0] =
                s.sample[p*ssq_pkg::PODW +: ssq_pkg::PODW];
          end
      endcase
    end
    // Toggle crossing; the word is stable long before the toggle lands
    next_s.tog_s1 = l.tog;
    next_s.tog_s2 = s.tog_s1;
    next_s.tog_s3 = s.tog_s2;
    if (s.tog_s2 != s.tog_s3)
    begin
      next_s.sample = l.out;
      next_s.count = s.count + 16'h0001;
      next_s.pulse = 1'b1;
    end
    if (RESET_IN)
    begin
      next_s = '0;
      next_s.arr_a = ssq_pkg::ARR_RST;
      next_s.arr_b = ssq_pkg::ARR_RST;
      next_s.modes = ssq_pkg::MODES_RST;
    end
  end

  // System domain register
  always_ff @(posedge CLK_SYS_IN)
  begin
    s <= next_s;
  end

  // ==========================================================
  // Link domain: pin sync, strobe qualification, capture
  always_comb
  begin
    logic [ssq_pkg::NPOD-1:0] nv;
    logic [ssq_pkg::NPOD-1:0] rise;
    logic [ssq_pkg::NPOD-1:0] fall;
    logic [ssq_pkg::NPOD-1:0] m;
    logic [ssq_pkg::MODEW-1:0] md;
    logic strobe_a;
    logic strobe_b;
    logic two;
    logic go;
    logic [ssq_pkg::DATW-1:0] acc;
    nv = '0;
    rise = '0;
    fall = '0;
    md = ssq_pkg::MODE_SINGLE;
    two = 1'b0;
    strobe_a = 1'b0;
    strobe_b = 1'b0;
    go = 1'b0;
    next_l = l;
    m = pod_mask(l.narrow);
    acc = l.acc;
    // Reset and run enable cross as levels
    next_l.rst_s1 = RESET_IN;
    next_l.rst_s2 = l.rst_s1;
    next_l.run_s1 = s.run & ~s.timing & ~s.err;
    next_l.run_s2 = l.run_s1;
    // Pins pass three stages; a change counts when stages two and three agree
    next_l.clk_s1 = EDGE_SRC_IN;
    next_l.clk_s2 = l.clk_s1;
    next_l.clk_s3 = l.clk_s2;
    next_l.dat_s1 = POD_DATA_IN;
    next_l.dat_s2 = l.dat_s1;
    next_l.dat_s3 = l.dat_s2;
    for (int i = 0; i < ssq_pkg::NPOD; i++)
      nv[i] = (l.clk_s2[i] == l.clk_s3[i]) ? l.clk_s3[i] : l.clk_v[i];
    next_l.clk_v = nv;
    rise = nv & ~l.clk_v;
    fall = ~nv & l.clk_v;
    strobe_a = arr_strobe(l.arr_a, rise, fall, nv, m);
    strobe_b = arr_strobe(l.arr_b, rise, fall, nv, m);
    for (int p = 0; p < ssq_pkg::NPOD; p++)
      if (m[p] && l.modes[p*ssq_pkg::MODEW +: ssq_pkg::MODEW] !=
          ssq_pkg::MODE_SINGLE)
        two = 1'b1;
    // Config is copied once when the unit arms; the write lock holds it still
    next_l.armed = l.run_s2;
    if (l.run_s2 && !l.armed)
    begin
      next_l.arr_a = s.arr_a;
      next_l.arr_b = s.arr_b;
      next_l.modes = s.modes;
      next_l.narrow = s.narrow;
      next_l.phase = ssq_pkg::PH_FIRST;
    end
    if (l.armed && l.run_s2)
    begin
      case (l.phase)
        ssq_pkg::PH_FIRST:
          if (strobe_a)
          begin
            for (int p = 0; p < ssq_pkg::NPOD; p++)
            begin
              md = l.modes[p*ssq_pkg::MODEW +: ssq_pkg::MODEW];
              if (!m[p])
                acc[p*ssq_pkg::PODW +: ssq_pkg::PODW] = 16'h0000;
              else if (md == ssq_pkg::MODE_SHARED || md == ssq_pkg::MODE_SPLIT)
              begin
                acc[p*ssq_pkg::PODW +: ssq_pkg::BYTEW] =
                  l.dat_s3[p*ssq_pkg::PODW +: ssq_pkg::BYTEW];
                acc[p*ssq_pkg::PODW+ssq_pkg::BYTEW +: ssq_pkg::BYTEW] = 8'h00;
              end
              else
                acc[p*ssq_pkg::PODW +: ssq_pkg::PODW] =
                  l.dat_s3[p*ssq_pkg::PODW +: ssq_pkg::PODW];
            end
            if (two)
              next_l.phase = ssq_pkg::PH_SECOND;
            else
              go = 1'b1;
          end
        ssq_pkg::PH_SECOND:
          if (strobe_b)
          begin
            for (int p = 0; p < ssq_pkg::NPOD; p++)
            begin
              md = l.modes[p*ssq_pkg::MODEW +: ssq_pkg::MODEW];
              // Shared line: second low byte lands above the first
              if (m[p] && md == ssq_pkg::MODE_SHARED)
                acc[p*ssq_pkg::PODW+ssq_pkg::BYTEW +: ssq_pkg::BYTEW] =
                  l.dat_s3[p*ssq_pkg::PODW +: ssq_pkg::BYTEW];
              else if (m[p] && md == ssq_pkg::MODE_SPLIT)
                acc[p*ssq_pkg::PODW+ssq_pkg::BYTEW +: ssq_pkg::BYTEW] =
                  l.dat_s3[p*ssq_pkg::PODW+ssq_pkg::BYTEW +:
                           ssq_pkg::BYTEW];
            end
            next_l.phase = ssq_pkg::PH_FIRST;
            go = 1'b1;
          end
        default: next_l.phase = ssq_pkg::PH_FIRST;
      endcase
    end
    next_l.acc = acc;
    // Merged sample published, then first phase re-arms
    if (go)
    begin
      next_l.out = acc;
      next_l.tog = ~l.tog;
    end
    if (l.rst_s2)
    begin
      next_l.armed = 1'b0;
      next_l.phase = ssq_pkg::PH_FIRST;
      next_l.acc = '0;
      next_l.out = '0;
      next_l.tog = 1'b0;
      next_l.arr_a = ssq_pkg::ARR_RST;
      next_l.arr_b = ssq_pkg::ARR_RST;
      next_l.modes = ssq_pkg::MODES_RST;
      next_l.narrow = 1'b0;
      next_l.clk_v = '0;
    end
  end

  // Link domain register
  always_ff @(posedge LINK_CLK_IN)
  begin
    l <= next_l;
  end

  // ==========================================================
  // Outputs straight from flops
  assign RD_DATA_OUT = s.rd_data;
  assign CFG_ERROR_OUT = s.err;
  assign SAMPLE_STROBE_OUT = s.pulse;

endmodule
`default_nettype wire

/* tb/ssq_properties.sv */
`default_nettype none
// ==========================================================
// Port-level checks for the sample clock qualifier
module ssq_properties
(
  // System side
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic [ssq_pkg::ADDRW-1:0] ADDR_IN,
  input wire logic [ssq_pkg::DW-1:0] WR_DATA_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [ssq_pkg::DW-1:0] RD_DATA_OUT,
  // Target side and status
  input wire logic [ssq_pkg::NPOD-1:0] EDGE_SRC_IN,
  input wire logic CFG_ERROR_OUT,
  input wire logic SAMPLE_STROBE_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run, timing, narrow;
  logic [7:0] idle_cnt, quiet_cnt, quiet_lo;
  logic [ssq_pkg::NPOD-1:0] last_src;

  // Shadow of control; narrow is frozen while running, as in the block
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RESET_IN)
    begin
      run <= 1'b0;
      timing <= 1'b0;
      narrow <= 1'b0;
    end
    else if (WR_EN_IN && ADDR_IN == ssq_pkg::OFF_CTRL)
    begin
      run <= WR_DATA_IN[ssq_pkg::CTRL_RUN];
      timing <= WR_DATA_IN[ssq_pkg::CTRL_TIMING];
      if (!run)
        narrow <= WR_DATA_IN[ssq_pkg::CTRL_NARROW];
    end
  end

  // Ages of idle capture and of the last clock pin change, saturating
  always_ff @(posedge CLK_SYS_IN)
  begin
    last_src <= EDGE_SRC_IN;
    if (RESET_IN || (run && !timing))
      idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hff)
      idle_cnt <= idle_cnt + 8'h01;
    if (RESET_IN || EDGE_SRC_IN != last_src)
      quiet_cnt <= 8'h00;
    else if (quiet_cnt != 8'hff)
      quiet_cnt <= quiet_cnt + 8'h01;
    if (RESET_IN || EDGE_SRC_IN[1:0] != last_src[1:0])
      quiet_lo <= 8'h00;
    else if (quiet_lo != 8'hff)
      quiet_lo <= quiet_lo + 8'h01;
  end

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RESET_IN);

  // ==========================================================
  // Assertions
  a_strobe_gap: assert property (
    SAMPLE_STROBE_OUT |=> !SAMPLE_STROBE_OUT [*4])
    else $error("sample strobe pulses too close");
  a_edge_cause: assert property (
    SAMPLE_STROBE_OUT |-> quiet_cnt < 8'd60)
    else $error("sample without a recent clock edge");
  a_err_quiet: assert property (
    CFG_ERROR_OUT [*8] |-> !SAMPLE_STROBE_OUT)
    else $error("sample taken with a level-only arrangement");
  a_err_status: assert property (
    RD_EN_IN && ADDR_IN == ssq_pkg::OFF_STATUS ##1 $stable(CFG_ERROR_OUT)
    |-> RD_DATA_OUT[ssq_pkg::STAT_ERR] == CFG_ERROR_OUT)
    else $error("status error bit differs from error output");
  a_idle_quiet: assert property (
    idle_cnt >= 8'd100 |-> !SAMPLE_STROBE_OUT)
    else $error("sample while stopped or in timing mode");
  a_narrow_zero: assert property (
    narrow && RD_EN_IN && ADDR_IN >= 8'h20 && ADDR_IN <= 8'h28
    |=> RD_DATA_OUT == '0)
    else $error("absent pod sample not zero on narrow part");
  a_narrow_src: assert property (
    narrow && SAMPLE_STROBE_OUT |-> quiet_lo < 8'd60)
    else $error("narrow part sampled on clocks 3 to 5");
  a_mode_width: assert property (
    RD_EN_IN && ADDR_IN == ssq_pkg::OFF_POD_MODE
    |=> RD_DATA_OUT[ssq_pkg::DW-1:ssq_pkg::MODESW] == '0)
    else $error("pod mode register wider than its fields");

  // Main scenarios reached
  c_sample: cover property (SAMPLE_STROBE_OUT);
  c_error: cover property (CFG_ERROR_OUT);
  c_narrow: cover property (narrow && SAMPLE_STROBE_OUT);
endmodule

bind ssq_top ssq_properties ssq_properties_inst (
  .CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN), .ADDR_IN(ADDR_IN),
  .WR_DATA_IN(WR_DATA_IN), .WR_EN_IN(WR_EN_IN), .RD_EN_IN(RD_EN_IN),
  .RD_DATA_OUT(RD_DATA_OUT), .EDGE_SRC_IN(EDGE_SRC_IN),
  .CFG_ERROR_OUT(CFG_ERROR_OUT), .SAMPLE_STROBE_OUT(SAMPLE_STROBE_OUT));
`default_nettype wire

/* tb/ssq_target_model.sv */
`default_nettype none
// ==========================================================
// Clock and data lines of the system under test
module ssq_target_model
(
  // Link clock from the bench
  input wire logic link_clk_in,
  // Pins toward the qualifier
  output logic [ssq_pkg::NPOD-1:0] edge_src_out,
  output logic [ssq_pkg::DATW-1:0] pod_data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet lines before the first bus cycle
  initial
  begin
    edge_src_out = '0;
    pod_data_out = '0;
  end

  // One target cycle: levels and data settle, edges pulse, then release
  task automatic cycle(input logic [4:0] lvl, input logic [4:0] edg,
                       input logic [79:0] data);
    @(posedge link_clk_in);
    pod_data_out <= data;
    edge_src_out <= lvl;
    repeat (6) @(posedge link_clk_in);
    edge_src_out <= lvl | edg;
    repeat (6) @(posedge link_clk_in);
    edge_src_out <= lvl;
    repeat (6) @(posedge link_clk_in);
    edge_src_out <= '0;
    // Released bus must not look like the old data
    pod_data_out <= ~data;
    repeat (6) @(posedge link_clk_in);
  endtask
endmodule
`default_nettype wire

/* tb/test_state_sample_clock_qualifier.sv */
`default_nettype none
// ==========================================================
// Self-checking bench for the sample clock qualifier
module test_state_sample_clock_qualifier;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(n, e, g) chk(n, e, g)
  localparam logic [7:0] S0 = ssq_pkg::OFF_SAMPLE0;
  localparam logic [7:0] CNT = ssq_pkg::OFF_COUNT;
  localparam logic [7:0] ST = ssq_pkg::OFF_STATUS;
  localparam logic [2:0] RISE = ssq_pkg::COND_RISE;
  logic clk_sys, rst, wr_en, rd_en, link_clk, cfg_error, sample_strobe;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data;
  logic [4:0] edge_src;
  logic [79:0] pod_data;
  logic [79:0] da = 80'h1f1e_2d2c_3b3a_4948_5756;
  logic [79:0] db = 80'ha1b2_c3d4_e5f6_0718_293a;
  logic [7:0] offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                           8'h18, 8'h80};
  logic [2:0] codes [4] = '{ssq_pkg::COND_OFF, ssq_pkg::COND_FALL,
                            ssq_pkg::COND_RISE, ssq_pkg::COND_EITHER};
  int want [4] = '{0, 1, 1, 2};
  int errors = 0;
  int samples_checked = 0;
  int cnt = 0;
  int pulses = 0;
  int cycles = 0;

  ssq_top ssq_top_inst (
    .CLK_SYS_IN(clk_sys), .RESET_IN(rst), .ADDR_IN(addr),
    .WR_DATA_IN(wr_data), .WR_EN_IN(wr_en), .RD_EN_IN(rd_en),
    .RD_DATA_OUT(rd_data), .LINK_CLK_IN(link_clk),
    .EDGE_SRC_IN(edge_src), .POD_DATA_IN(pod_data),
    .CFG_ERROR_OUT(cfg_error), .SAMPLE_STROBE_OUT(sample_strobe));
  ssq_target_model ssq_target_model_inst (.link_clk_in(link_clk),
    .edge_src_out(edge_src), .pod_data_out(pod_data));

  // ==========================================================
  // Clocks: link clock offset by 3 ns; every fifth link rising edge still lines up with a system one
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    link_clk = 1'b0;
    #3;
    forever #32 link_clk = ~link_clk;
  end

  // Pulse tally and hang guard, about seven times the expected run
  always @(posedge clk_sys)
  begin
    cycles++;
    if (sample_strobe === 1'b1)
      pulses++;
    if (cycles == 20000)
    begin
      errors++;
      wrap_up();
    end
  end

  // ==========================================================
  // Access tasks
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    `CHK(n, e, rd_data);
  endtask
  // Config writes are locked while running, so stop first
  task automatic cfg(input logic [14:0] a, input logic [14:0] b,
                     input logic [9:0] m, input logic [2:0] c);
    wr(ssq_pkg::OFF_CTRL, 32'h0);
    wr(ssq_pkg::OFF_ARR_A, 32'(a));
    wr(ssq_pkg::OFF_ARR_B, 32'(b));
    wr(ssq_pkg::OFF_POD_MODE, 32'(m));
    wr(ssq_pkg::OFF_CTRL, 32'(c & 3'h6));
    wr(ssq_pkg::OFF_CTRL, 32'(c));
  endtask
  function automatic logic [14:0] on(input int i, input logic [2:0] c);
    return 15'(c) << (3 * i);
  endfunction
  task automatic tgt(input logic [4:0] l, input logic [4:0] e,
                     input logic [79:0] d);
    ssq_target_model_inst.cycle(l, e, d);
  endtask
  task automatic wrap_up();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Test sequence
  initial
  begin
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0;
    // Three link cycles, so the link domain sees reset too
    repeat (3) @(posedge link_clk);
    @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge link_clk);
    foreach (offs[i])
      rd(offs[i], 32'h0, "reset value");
    // Every edge code on clock 1, all pods single phase
    foreach (codes[i])
    begin
      cfg(on(0, codes[i]), 15'h0, 10'h0, 3'h1);
      tgt(5'h00, 5'h01, da);
      cnt += want[i];
      rd(CNT, 32'(cnt), "count per code");
    end
    for (int p = 0; p < 5; p++)
      rd(8'(S0 + 4 * p), 32'(da[16 * p +: 16]), "single pod");
    // Edges ORed, levels ORed, the two ANDed; clock 5 included
    cfg(on(0, RISE) | on(1, RISE) | on(4, RISE) |
        on(2, ssq_pkg::COND_HIGH) | on(3, ssq_pkg::COND_LOW),
        15'h0, 10'h0, 3'h1);
    tgt(5'h04, 5'h02, db);
    tgt(5'h08, 5'h01, db);
    tgt(5'h00, 5'h10, db);
    cnt += 2;
    rd(CNT, 32'(cnt), "and of or terms");
    // Level-only arrangement is refused
    cfg(on(0, ssq_pkg::COND_HIGH), 15'h0, 10'h0, 3'h1);
    repeat (10) @(posedge clk_sys);
    `CHK("error flag", 32'h1, 32'(cfg_error));
    rd(ST, 32'h1, "status error");
    wr(ssq_pkg::OFF_ARR_A, 32'(on(0, RISE)));
    rd(ssq_pkg::OFF_ARR_A, 32'(on(0, ssq_pkg::COND_HIGH)), "locked");
    tgt(5'h01, 5'h00, da);
    rd(CNT, 32'(cnt), "no level-only capture");
    // Timing mode never uses the arrangement
    cfg(on(0, RISE), 15'h0, 10'h0, 3'h3);
    rd(ST, 32'h0, "timing inactive");
    tgt(5'h00, 5'h01, da);
    rd(CNT, 32'(cnt), "timing no capture");
    // Pod 1 shared split, pod 2 split byte, the rest single
    cfg(on(0, RISE), on(1, RISE), 10'h009, 3'h1);
    tgt(5'h00, 5'h01, da);
    tgt(5'h00, 5'h01, ~da);
    rd(CNT, 32'(cnt), "half sample");
    tgt(5'h00, 5'h02, db);
    cnt++;
    rd(CNT, 32'(cnt), "merged sample");
    rd(S0, {16'h0, db[7:0], da[7:0]}, "shared split");
    rd(S0 + 8'h04, {16'h0, db[31:24], da[23:16]}, "split");
    rd(S0 + 8'h08, {16'h0, da[47:32]}, "single in mix");
    // Same arrangement for both phases
    cfg(on(0, RISE), on(0, RISE), 10'h001, 3'h1);
    tgt(5'h00, 5'h01, db);
    tgt(5'h00, 5'h01, da);
    cnt++;
    rd(S0, {16'h0, da[7:0], db[7:0]}, "same arrangement");
    // Narrow part: clock 3 and pods 3 to 5 are absent
    cfg(on(0, RISE) | on(2, RISE), 15'h0, 10'h0, 3'h5);
    tgt(5'h00, 5'h04, da);
    rd(CNT, 32'(cnt), "narrow clock 3");
    tgt(5'h00, 5'h01, db);
    cnt++;
    rd(CNT, 32'(cnt), "narrow clock 1");
    rd(S0 + 8'h04, {16'h0, db[31:16]}, "narrow pod 2");
    rd(S0 + 8'h08, 32'h0, "narrow pod 3");
    wr(ssq_pkg::OFF_CTRL, 32'h0);
    `CHK("pulses", 32'(cnt), 32'(pulses));
    wrap_up();
  end
endmodule
`default_nettype wire
